// file: hdl/ccsu_pkg.sv
// Constants and carrier types for the common command and status unit.
// Assumes a parser upstream that hands over one decoded common command at a time.
//
// Notes on behaviour
// - Identity answer: maker, model, serial, revision.
// - Identity query not last: query error, mute.
// - Reset restores settings, keeps interface configuration.
// - Reset during wait or measure enters hold.
// - Self-test answers zero pass, minus one fail.
// - Self-test while busy: execution error, no answer.
// - Completion command sets bit 0 when idle.
// - Completion query answers one, leaves events alone.
// - Wait command stalls later commands until idle.
// - Clear status zeroes events and dependent summaries.
// - Event mask clamped to 0..255, error flagged.
// - Mask bit one passes event to summary.
// - Mask queries report bits 6, 1 zero; SRE query also bit 2.
// - Event bits: 7,5,4,3,2,0 used; 6,1 unused.
// - Event query returns register and clears it.
// - Power-on clear flag governs mask clearing.
// - Flag zero keeps masks; nonzero clears; reads 0/1.
// - Save and recall setups in numbered slots.
// - Trigger starts measurement only during trigger wait.
// - Master summary: OR of enabled bits except 6.
package ccsu_pkg;

  // ==========================================================================
  // Command codes
  // ==========================================================================
  typedef enum logic [4:0] {
    OP_IDNQ = 5'h00,
    OP_RST  = 5'h01,
    OP_TSTQ = 5'h02,
    OP_OPC  = 5'h03,
    OP_OPCQ = 5'h04,
    OP_WAI  = 5'h05,
    OP_CLS  = 5'h06,
    OP_ESE  = 5'h07,
    OP_ESEQ = 5'h08,
    OP_ESRQ = 5'h09,
    OP_PSC  = 5'h0a,
    OP_PSCQ = 5'h0b,
    OP_SRE  = 5'h0c,
    OP_SREQ = 5'h0d,
    OP_STBQ = 5'h0e,
    OP_TRG  = 5'h0f,
    OP_RCL  = 5'h10,
    OP_SAV  = 5'h11
  } ccsu_op_t;

  typedef enum logic [1:0] {
    S_INIT = 2'h0,
    S_IDLE = 2'h1,
    S_WAIT = 2'h2,
    S_IDN  = 2'h3
  } ccsu_state_t;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    ccsu_op_t           op;
    logic signed [31:0] arg;
    logic               more_q;   // Another query follows in this message.
    logic               msg_end;  // Last unit of the program message.
  } ccsu_cmd_t;

  typedef struct packed {
    logic [1:0]         field;    // Field index of a multi-field answer.
    logic               last;     // Final word of this answer.
    logic signed [31:0] value;
  } ccsu_resp_t;

  typedef struct packed {
    logic ops;   // Operation event summary.
    logic mav;   // Message available.
    logic qes;   // Questionable event summary.
    logic mev;   // Measurement event summary.
  } ccsu_sum_t;

  // ==========================================================================
  // Status layout
  // ==========================================================================
  localparam int ESR_PON = 7;
  localparam int ESR_CME = 5;
  localparam int ESR_EXE = 4;
  localparam int ESR_DDE = 3;
  localparam int ESR_QYE = 2;
  localparam int ESR_OPC = 0;

  localparam logic [7:0] ESE_READ_MASK = 8'hbd;
  localparam logic [7:0] SRE_READ_MASK = 8'hb9;
  localparam logic [7:0] SRE_MSS_MASK  = 8'hbf;
  localparam logic [7:0] MASK_MAX      = 8'hff;
  localparam logic [7:0] MASK_RESET    = 8'h00;

  localparam int STB_OPS = 7;
  localparam int STB_MSS = 6;
  localparam int STB_ESB = 5;
  localparam int STB_MAV = 4;
  localparam int STB_QES = 3;
  localparam int STB_MEV = 0;

  localparam logic signed [31:0] ARG_MAX   = 32'sh0000_00ff;
  localparam logic signed [31:0] TST_PASS  = 32'sh0000_0000;
  localparam logic signed [31:0] TST_FAIL  = -32'sh0000_0001;
  localparam logic signed [31:0] OPC_REPLY = 32'sh0000_0001;
  localparam logic        [3:0]  SLOT_MAX  = 4'h9;

  localparam logic [1:0] IDN_MAKER = 2'h0;
  localparam logic [1:0] IDN_MODEL = 2'h1;
  localparam logic [1:0] IDN_SER   = 2'h2;
  localparam logic [1:0] IDN_REV   = 2'h3;

endpackage

// file: hdl/ccsu_evbit.sv
// One sticky event status bit.
// Assumes set and clear are single-cycle pulses on mclk.
`timescale 1ns/1ns
module ccsu_evbit (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic set,
  input  wire logic clr,
  output logic      q
);

  // ==========================================================================
  // Storage
  // ==========================================================================
  // An event landing in the clearing cycle survives, so no event is lost.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= 1'b0;
    end else if (ce) begin
      if (set) begin
        q <= 1'b1;
      end else if (clr) begin
        q <= 1'b0;
      end
    end
  end

endmodule

// file: hdl/ccsu_top.sv
// Common command interpreter with the standard event and status byte logic.
// Assumes decoded commands and instrument status arrive on mclk, so no pin
// synchronisers are needed apart from the reset release.
`timescale 1ns/1ns
module ccsu_top #(
  parameter logic signed [31:0] MAKER_CODE = 32'sh0000_0a5a, // Arbitrary value.
  parameter logic signed [31:0] MODEL_CODE = 32'sh0000_1234, // Arbitrary value.
  parameter logic signed [31:0] SERIAL_NUM = 32'sh0000_0001,
  parameter logic signed [31:0] FW_REV     = 32'sh0000_0064
) (
  input  wire logic                mclk,
  input  wire logic                nrst,
  input  wire logic                ce,
  input  wire logic                cmd_valid,
  input  wire ccsu_pkg::ccsu_cmd_t cmd,
  output logic                     cmd_ready,
  output logic                     resp_valid,
  output ccsu_pkg::ccsu_resp_t     resp,
  input  wire logic                op_busy,
  input  wire logic                trig_wait,
  input  wire logic                measuring,
  input  wire logic                selftest_ok,
  input  wire logic                cmd_err_evt,
  input  wire logic                dev_err_evt,
  input  wire ccsu_pkg::ccsu_sum_t inst_sum,
  input  wire logic                psc_nv,
  input  wire logic [7:0]          ese_nv,
  input  wire logic [7:0]          sre_nv,
  output logic                     settings_rst,
  output logic                     hold_req,
  output logic                     trig_start,
  output logic                     setup_save,
  output logic                     setup_recall,
  output logic [3:0]               setup_slot,
  output logic                     inst_ev_clr,
  output logic                     psc_flag,
  output logic [7:0]               ese_mask,
  output logic [7:0]               sre_mask,
  output logic [7:0]               esr,
  output logic [7:0]               stb
);
  import ccsu_pkg::*;

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ==========================================================================
  // Command decode
  // ==========================================================================
  ccsu_state_t state_r;
  logic        wait_opc_r;
  logic        wait_opcq_r;
  logic [1:0]  idn_idx_r;
  logic        mute_r;
  logic        take;
  logic        busy_meas;
  logic        is_query;
  logic        arg_lo;
  logic        arg_hi;
  logic [7:0]  arg_mask;
  logic        slot_ok;
  logic        opc_set;
  logic        exe_set;
  logic        qye_set;
  logic        pon_set;
  logic        esr_clr;
  logic [7:0]  esr_bits;

  assign take      = ce && cmd_valid && cmd_ready;
  assign busy_meas = trig_wait || measuring;
  assign arg_lo    = cmd.arg < 0;
  assign arg_hi    = cmd.arg > ARG_MAX;
  assign arg_mask  = arg_lo ? MASK_RESET : (arg_hi ? MASK_MAX : cmd.arg[7:0]);
  assign slot_ok   = !arg_lo && (cmd.arg <= 32'(SLOT_MAX));

  always_comb begin
    case (cmd.op)
      OP_IDNQ, OP_TSTQ, OP_OPCQ, OP_ESEQ, OP_ESRQ, OP_PSCQ, OP_SREQ, OP_STBQ: begin
        is_query = 1'b1;
      end
      default: begin
        is_query = 1'b0;
      end
    endcase
  end

  always_comb begin
    exe_set = 1'b0;
    esr_clr = 1'b0;
    if (take) begin
      case (cmd.op)
        OP_TSTQ: begin
          exe_set = busy_meas;
        end
        OP_ESE, OP_SRE: begin
          exe_set = arg_lo || arg_hi;
        end
        OP_TRG: begin
          exe_set = !trig_wait;
        end
        OP_SAV, OP_RCL: begin
          exe_set = !slot_ok;
        end
        OP_CLS, OP_ESRQ: begin
          esr_clr = 1'b1;
        end
        default: begin
          exe_set = 1'b0;
        end
      endcase
    end
  end

  assign qye_set = take && (cmd.op == OP_IDNQ) && cmd.more_q;
  assign opc_set = (state_r == S_WAIT) && ce && wait_opc_r && !op_busy;
  assign pon_set = (state_r == S_INIT) && ce;

  // ==========================================================================
  // Event status register
  // ==========================================================================
  localparam int NEV = 6;
  localparam int EV_POS [NEV] = '{ESR_PON, ESR_CME, ESR_EXE, ESR_DDE, ESR_QYE, ESR_OPC};
  logic [NEV-1:0] ev_set;
  logic [NEV-1:0] ev_q;

  assign ev_set = {pon_set, cmd_err_evt, exe_set, dev_err_evt, qye_set, opc_set};

  genvar gi;
  generate
    for (gi = 0; gi < NEV; gi++) begin : g_ev
      ccsu_evbit u_ev (
        .mclk  (mclk),
        .rst_n (rst_n_r),
        .ce    (ce),
        .set   (ev_set[NEV-1-gi]),
        .clr   (esr_clr),
        .q     (ev_q[NEV-1-gi])
      );
    end
  endgenerate

  // Unused positions 6 and 1 stay zero by construction.
  always_comb begin
    esr_bits = 8'h00;
    for (int i = 0; i < NEV; i++) begin
      esr_bits[EV_POS[i]] = ev_q[NEV-1-i];
    end
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  // Ready drops in the cycle a stalling command is taken, so nothing slips
  // in behind a wait or a multi-word answer.
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r     <= S_INIT;
      cmd_ready   <= 1'b0;
      wait_opc_r  <= 1'b0;
      wait_opcq_r <= 1'b0;
      idn_idx_r   <= 2'h0;
    end else if (ce) begin
      case (state_r)
        S_INIT: begin
          state_r   <= S_IDLE;
          cmd_ready <= 1'b1;
        end
        S_IDLE: begin
          if (take && (cmd.op == OP_OPC || cmd.op == OP_OPCQ || cmd.op == OP_WAI)) begin
            state_r     <= S_WAIT;
            cmd_ready   <= 1'b0;
            wait_opc_r  <= cmd.op == OP_OPC;
            wait_opcq_r <= cmd.op == OP_OPCQ;
          end else if (take && cmd.op == OP_IDNQ && !mute_r && !cmd.more_q) begin
            state_r   <= S_IDN;
            cmd_ready <= 1'b0;
            idn_idx_r <= IDN_MODEL;
          end
        end
        S_WAIT: begin
          if (!op_busy) begin
            state_r   <= S_IDLE;
            cmd_ready <= 1'b1;
          end
        end
        S_IDN: begin
          idn_idx_r <= idn_idx_r + 2'h1;
          if (idn_idx_r == IDN_REV) begin
            state_r   <= S_IDLE;
            cmd_ready <= 1'b1;
          end
        end
        default: begin
          state_r   <= S_INIT;
          cmd_ready <= 1'b0;
        end
      endcase
    end
  end

  // Answers after a misplaced identity query stay muted to the message end.
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mute_r <= 1'b0;
    end else if (take) begin
      if (cmd.msg_end) begin
        mute_r <= 1'b0;
      end else if (qye_set) begin
        mute_r <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Answers
  // ==========================================================================
  logic signed [31:0] idn_word;

  always_comb begin
    case (idn_idx_r)
      IDN_MODEL: idn_word = MODEL_CODE;
      IDN_SER:   idn_word = SERIAL_NUM;
      IDN_REV:   idn_word = FW_REV;
      default:   idn_word = MAKER_CODE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      resp_valid <= 1'b0;
      resp       <= '0;
    end else if (ce) begin
      resp_valid <= 1'b0;
      resp.field <= 2'h0;
      resp.last  <= 1'b1;
      if (state_r == S_IDN) begin
        resp_valid <= 1'b1;
        resp.field <= idn_idx_r;
        resp.last  <= idn_idx_r == IDN_REV;
        resp.value <= idn_word;
      end else if (state_r == S_WAIT && wait_opcq_r && !op_busy && !mute_r) begin
        resp_valid <= 1'b1;
        resp.value <= OPC_REPLY;
      end else if (take && is_query && !mute_r) begin
        resp_valid <= 1'b1;
        case (cmd.op)
          OP_IDNQ: begin
            resp_valid <= !cmd.more_q;
            resp.field <= IDN_MAKER;
            resp.last  <= 1'b0;
            resp.value <= MAKER_CODE;
          end
          OP_TSTQ: begin
            resp_valid <= !busy_meas;
            resp.value <= selftest_ok ? TST_PASS : TST_FAIL;
          end
          OP_ESEQ: resp.value <= 32'(ese_mask & ESE_READ_MASK);
          OP_ESRQ: resp.value <= 32'(esr_bits);
          OP_PSCQ: resp.value <= 32'(psc_flag);
          OP_SREQ: resp.value <= 32'(sre_mask & SRE_READ_MASK);
          OP_STBQ: resp.value <= 32'(stb);
          default: resp_valid <= 1'b0;
        endcase
      end
    end
  end

  // ==========================================================================
  // Masks and power-on clear
  // ==========================================================================
  // Masks come from retained storage at start-up unless the flag asks for a
  // clear; the write-back ports let the system keep them across power loss.
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      psc_flag <= 1'b0;
      ese_mask <= MASK_RESET;
      sre_mask <= MASK_RESET;
    end else if (ce) begin
      if (state_r == S_INIT) begin
        psc_flag <= psc_nv;
        ese_mask <= psc_nv ? MASK_RESET : ese_nv;
        sre_mask <= psc_nv ? MASK_RESET : sre_nv;
      end else if (take) begin
        case (cmd.op)
          OP_PSC:  psc_flag <= cmd.arg != 0;
          OP_ESE:  ese_mask <= arg_mask;
          OP_SRE:  sre_mask <= arg_mask;
          default: psc_flag <= psc_flag;
        endcase
      end
    end
  end

  // ==========================================================================
  // Status outputs
  // ==========================================================================
  logic [7:0] stb_nxt;

  always_comb begin
    stb_nxt          = 8'h00;
    stb_nxt[STB_OPS] = inst_sum.ops;
    stb_nxt[STB_ESB] = |(esr_bits & ese_mask);
    stb_nxt[STB_MAV] = inst_sum.mav;
    stb_nxt[STB_QES] = inst_sum.qes;
    stb_nxt[STB_MEV] = inst_sum.mev;
    stb_nxt[STB_MSS] = |(stb_nxt & sre_mask & SRE_MSS_MASK);
  end

  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      esr <= 8'h00;
      stb <= 8'h00;
    end else if (ce) begin
      esr <= esr_bits;
      stb <= stb_nxt;
    end
  end

  // ==========================================================================
  // Instrument strobes
  // ==========================================================================
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      settings_rst <= 1'b0;
      hold_req     <= 1'b0;
      trig_start   <= 1'b0;
      setup_save   <= 1'b0;
      setup_recall <= 1'b0;
      setup_slot   <= 4'h0;
      inst_ev_clr  <= 1'b0;
    end else if (ce) begin
      settings_rst <= take && cmd.op == OP_RST;
      hold_req     <= take && cmd.op == OP_RST && busy_meas;
      trig_start   <= take && cmd.op == OP_TRG && trig_wait;
      setup_save   <= take && cmd.op == OP_SAV && slot_ok;
      setup_recall <= take && cmd.op == OP_RCL && slot_ok;
      inst_ev_clr  <= take && cmd.op == OP_CLS;
      if (take && (cmd.op == OP_SAV || cmd.op == OP_RCL) && slot_ok) begin
        setup_slot <= cmd.arg[3:0];
      end
    end
  end

endmodule

// file: dv/ccsu_top_sva.sv
// Checker for answers, strobes and summaries of the unit.
// Assumes it is bound to ccsu_top and sees only that module's ports.
`timescale 1ns/1ns
module ccsu_top_sva
  import ccsu_pkg::*;
(
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic       ce,
  input wire logic       cmd_valid,
  input wire ccsu_cmd_t  cmd,
  input wire logic       cmd_ready,
  input wire logic       resp_valid,
  input wire ccsu_resp_t resp,
  input wire logic       trig_wait,
  input wire logic       measuring,
  input wire logic       cmd_err_evt,
  input wire logic       dev_err_evt,
  input wire logic       settings_rst,
  input wire logic       hold_req,
  input wire logic       trig_start,
  input wire logic       inst_ev_clr,
  input wire logic [7:0] ese_mask,
  input wire logic [7:0] sre_mask,
  input wire logic [7:0] esr,
  input wire logic [7:0] stb
);
  wire logic take = ce && cmd_valid && cmd_ready;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  a_ese_query: assert property (
    take && cmd.op == OP_ESEQ ##1 resp_valid |-> resp.value == {24'h0, ese_mask & 8'hbd})
    else $error("mask query answer wrong");
  a_esb_summary: assert property (
    $stable(ese_mask) |-> stb[STB_ESB] == |(esr & ese_mask))
    else $error("event summary bit wrong");
  a_mss_summary: assert property (
    $stable(sre_mask) |-> stb[STB_MSS] == |(stb & sre_mask & 8'hbf))
    else $error("master summary bit wrong");
  a_tst_busy: assert property (
    take && cmd.op == OP_TSTQ && (trig_wait || measuring) |=> !resp_valid)
    else $error("self test answered while busy");
  a_trg_start: assert property (
    take && cmd.op == OP_TRG && trig_wait |-> ##[1:2] trig_start)
    else $error("trigger did not start");
  a_rst_hold: assert property (
    take && cmd.op == OP_RST && (trig_wait || measuring) |-> ##[1:2] (settings_rst && hold_req))
    else $error("reset did not hold");
  a_cls_clear: assert property (
    take && cmd.op == OP_CLS |-> ##[1:2] inst_ev_clr)
    else $error("no event clear");
  a_esr_clear: assert property (
    take && cmd.op == OP_ESRQ && !cmd_err_evt && !dev_err_evt
    ##1 (!cmd_valid && !cmd_err_evt && !dev_err_evt) [*3] |-> esr == 8'h00)
    else $error("read did not clear");
  a_wait_stall: assert property (
    take && (cmd.op == OP_OPC || cmd.op == OP_WAI) |=> !cmd_ready)
    else $error("completion wait did not stall");
endmodule

bind ccsu_top ccsu_top_sva ccsu_top_sva_inst (
  .mclk, .nrst, .ce, .cmd_valid, .cmd, .cmd_ready, .resp_valid, .resp, .trig_wait,
  .measuring, .cmd_err_evt, .dev_err_evt, .settings_rst, .hold_req, .trig_start,
  .inst_ev_clr, .ese_mask, .sre_mask, .esr, .stb
);

// file: dv/ccsu_engine_model.sv
// Measurement engine and retained store behind the unit.
// Assumes the bench arms trigger wait; power loss is modelled by nrst.
`timescale 1ns/1ns
module ccsu_engine_model (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       arm,
  input  wire logic       trig_start,
  input  wire logic       hold_req,
  input  wire logic       cmd_ready,
  input  wire logic       psc_flag,
  input  wire logic [7:0] ese_mask,
  input  wire logic [7:0] sre_mask,
  output logic            op_busy,
  output logic            trig_wait,
  output logic            measuring,
  output logic            psc_nv,
  output logic [7:0]      ese_nv,
  output logic [7:0]      sre_nv
);
  logic       tw_r;
  logic [2:0] cnt_r;
  logic       alive_r;
  logic       psc_r = 1'b0;
  logic [7:0] ese_r = 8'h00;
  logic [7:0] sre_r = 8'h00;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tw_r <= 1'b0;
      cnt_r <= 3'h0;
    end else if (hold_req) begin
      tw_r <= 1'b0;
      cnt_r <= 3'h0;
    end else if (trig_start) begin
      tw_r <= 1'b0;
      cnt_r <= 3'h5;
    end else begin
      tw_r <= tw_r | arm;
      cnt_r <= cnt_r - 3'(cnt_r != 3'h0);
    end
  end
  // Store tracks the unit only once it is up.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      alive_r <= 1'b0;
      if (psc_r) begin
        ese_r <= 8'h00;
        sre_r <= 8'h00;
      end
    end else begin
      alive_r <= alive_r | cmd_ready;
      if (alive_r) begin
        psc_r <= psc_flag;
        ese_r <= ese_mask;
        sre_r <= sre_mask;
      end
    end
  end
  assign trig_wait = tw_r;
  assign measuring = cnt_r != 3'h0;
  assign op_busy   = measuring;
  assign psc_nv    = psc_r;
  assign ese_nv    = ese_r;
  assign sre_nv    = sre_r;
endmodule

// file: dv/ccsu_top_test.sv
// Bench: common command sequences with expected answers.
// Assumes the engine model and the bound checker.
`timescale 1ns/1ns
module ccsu_top_test;
  import ccsu_pkg::*;
  // Maker and model codes are arbitrary values.
  localparam logic signed [31:0] IDV [4] = '{32'sh0c0d, 32'sh0777, 32'sd12345, 32'sd207};
  logic        mclk        = 1'b0;
  logic        nrst        = 1'b0;
  logic        ce          = 1'b1;
  logic        cmd_valid   = 1'b0;
  ccsu_cmd_t   cmd         = '0;
  logic        selftest_ok = 1'b1;
  logic        cmd_err_evt = 1'b0;
  logic        dev_err_evt = 1'b0;
  ccsu_sum_t   inst_sum    = '0;
  logic        arm         = 1'b0;
  logic        cmd_ready, resp_valid, op_busy, trig_wait, measuring, psc_nv;
  logic        settings_rst, hold_req, trig_start, setup_save, setup_recall;
  logic        inst_ev_clr, psc_flag;
  logic [3:0]  setup_slot;
  logic [7:0]  ese_mask, sre_mask, esr, stb, ese_nv, sre_nv;
  ccsu_resp_t  resp;
  logic [31:0] sc [6] = '{default: 32'h0};
  logic [3:0]  last_slot = 4'h0;
  logic [31:0] rv [4];
  logic [2:0]  rf [4];
  int          nw;
  int          fail_count = 0;
  int          n_compared = 0;
  ccsu_top #(.MAKER_CODE(IDV[0]), .MODEL_CODE(IDV[1]), .SERIAL_NUM(IDV[2]), .FW_REV(IDV[3]))
  ccsu_top_inst (.mclk, .nrst, .ce, .cmd_valid, .cmd, .cmd_ready, .resp_valid, .resp,
    .op_busy, .trig_wait, .measuring, .selftest_ok, .cmd_err_evt, .dev_err_evt, .inst_sum,
    .psc_nv, .ese_nv, .sre_nv, .settings_rst, .hold_req, .trig_start, .setup_save,
    .setup_recall, .setup_slot, .inst_ev_clr, .psc_flag, .ese_mask, .sre_mask, .esr, .stb);
  ccsu_engine_model ccsu_engine_model_inst (.mclk, .nrst, .arm, .trig_start, .hold_req,
    .cmd_ready, .psc_flag, .ese_mask, .sre_mask, .op_busy, .trig_wait, .measuring, .psc_nv,
    .ese_nv, .sre_nv);
  initial begin
    forever #10 mclk = ~mclk;
  end
  // Strobes are counted so that single-cycle pulses are never missed.
  always @(posedge mclk) begin
    for (int i = 0; i < 6; i++) begin
      if ({inst_ev_clr, setup_recall, setup_save, trig_start, hold_req, settings_rst}
          >> i & 6'h1) begin
        sc[i] <= sc[i] + 32'h1;
      end
    end
    if ((setup_save | setup_recall) === 1'b1) begin
      last_slot <= setup_slot;
    end
  end
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ec(input string nm, input logic [31:0] e);
    q(OP_ESRQ);
    chk(nm, e, rv[0]);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic send(input ccsu_op_t op, input int a = 0, input logic mq = 1'b0,
                      input logic me = 1'b1);
    int k;
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd <= '{op, a, mq, me};
    for (k = 0; k < 40; k++) begin
      @(posedge mclk);
      if (cmd_ready === 1'b1) break;
    end
    cmd_valid <= 1'b0;
    if (k == 40) begin
      chk("cmd_take", 32'h1, 32'h0);
      wrap_up();
    end
  endtask
  task automatic q(input ccsu_op_t op, input int a = 0, input logic mq = 1'b0,
                   input logic me = 1'b1);
    send(op, a, mq, me);
    nw = 0;
    repeat (10) begin
      @(posedge mclk);
      if (resp_valid === 1'b1 && nw < 4) begin
        rv[nw] = resp.value;
        rf[nw] = {resp.field, resp.last};
        nw++;
      end
    end
  endtask
  task automatic arm_t();
    @(posedge mclk);
    arm <= 1'b1;
    @(posedge mclk);
    arm <= 1'b0;
  endtask
  task automatic pwr();
    @(posedge mclk);
    nrst <= 1'b0;
    idle(16);
    nrst <= 1'b1;
    idle(8);
  endtask
  initial begin
    #1000000;
    chk("timeout", 32'h1, 32'h0);
    wrap_up();
  end
  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    int          ca [4] = '{300, -5, 255, 0};
    logic [7:0]  cm [4] = '{8'hff, 8'h00, 8'hff, 8'h00};
    logic [31:0] cx [4] = '{32'h10, 32'h10, 32'h0, 32'h0};
    pwr();
    ec("esr_pon", 32'h80);
    ec("esr_read_clear", 32'h0);
    q(OP_IDNQ);
    chk("idn_words", 32'h4, 32'(nw));
    for (int i = 0; i < 4; i++) begin
      chk("idn_value", IDV[i], rv[i]);
      chk("idn_field", 32'({i[1:0], i == 3}), 32'(rf[i]));
    end
    q(OP_IDNQ, 0, 1'b1, 1'b0);
    chk("idn_misplaced", 32'h0, 32'(nw));
    q(OP_ESEQ, 0, 1'b0, 1'b0);
    chk("idn_muted_query", 32'h0, 32'(nw));
    send(OP_ESE, 0);
    ec("idn_query_error", 32'h4);
    $display("test identity done");
    for (int i = 0; i < 4; i++) begin
      send(OP_ESE, ca[i]);
      q(OP_ESEQ);
      chk("ese_query", 32'(cm[i] & 8'hbd), rv[0]);
      chk("ese_mask", 32'(cm[i]), 32'(ese_mask));
      ec("ese_clamp_error", cx[i]);
    end
    send(OP_ESE, 32);
    send(OP_SRE, 32);
    @(posedge mclk);
    cmd_err_evt <= 1'b1;
    @(posedge mclk);
    cmd_err_evt <= 1'b0;
    idle(4);
    chk("esr_cme", 32'h20, 32'(esr));
    chk("stb_enabled", 32'h60, 32'(stb));
    send(OP_ESE, 16);
    idle(4);
    chk("stb_masked", 32'h0, 32'(stb));
    send(OP_ESE, 32);
    send(OP_CLS);
    idle(4);
    chk("cls_esr", 32'h0, 32'(esr));
    chk("cls_stb", 32'h0, 32'(stb));
    chk("cls_inst_clear", 32'h1, sc[5]);
    $display("test masks done");
    q(OP_TSTQ);
    chk("tst_pass", 32'h0, rv[0]);
    @(posedge mclk);
    selftest_ok <= 1'b0;
    q(OP_TSTQ);
    chk("tst_fail", 32'hffffffff, rv[0]);
    selftest_ok <= 1'b1;
    arm_t();
    q(OP_TSTQ);
    chk("tst_busy_words", 32'h0, 32'(nw));
    ec("tst_busy_error", 32'h10);
    send(OP_TRG);
    send(OP_OPC);
    idle(2);
    chk("opc_stall", 32'h0, 32'(cmd_ready));
    ec("opc_bit", 32'h1);
    chk("trg_started", 32'h1, sc[2]);
    send(OP_TRG);
    ec("trg_idle_error", 32'h10);
    chk("trg_idle_start", 32'h1, sc[2]);
    arm_t();
    send(OP_TRG);
    q(OP_OPCQ);
    chk("opcq_words", 32'h1, 32'(nw));
    chk("opcq_value", 32'h1, rv[0]);
    ec("opcq_esr", 32'h0);
    arm_t();
    send(OP_TRG);
    send(OP_WAI);
    send(OP_CLS);
    chk("wai_hold", 32'h0, 32'(measuring));
    $display("test completion done");
    arm_t();
    send(OP_RST);
    idle(3);
    chk("rst_settings", 32'h1, sc[0]);
    chk("rst_hold", 32'h1, sc[1]);
    send(OP_RST);
    idle(3);
    chk("rst_idle_settings", 32'h2, sc[0]);
    chk("rst_idle_hold", 32'h1, sc[1]);
    send(OP_SAV, 3);
    idle(3);
    chk("sav_strobe", 32'h1, sc[3]);
    chk("sav_slot", 32'h3, 32'(last_slot));
    send(OP_RCL, 12);
    ec("rcl_range_error", 32'h10);
    send(OP_RCL, 9);
    idle(3);
    chk("rcl_strobe", 32'h1, sc[4]);
    chk("rcl_slot", 32'h9, 32'(last_slot));
    $display("test setups done");
    send(OP_ESE, 32);
    send(OP_SRE, 32);
    send(OP_PSC, 5);
    q(OP_PSCQ);
    chk("psc_query_one", 32'h1, rv[0]);
    pwr();
    chk("psc_ese_cleared", 32'h0, 32'(ese_mask));
    chk("psc_sre_cleared", 32'h0, 32'(sre_mask));
    send(OP_PSC, 0);
    send(OP_ESE, 4);
    idle(4);
    pwr();
    chk("psc_ese_kept", 32'h4, 32'(ese_mask));
    q(OP_PSCQ);
    chk("psc_query_zero", 32'h0, rv[0]);
    $display("test power done");
    wrap_up();
  end
endmodule
